// File: hw/en_margin_pkg.sv
// constants, types and register layout for the enable and margin control block
package en_margin_pkg;

   // ************************************************************
   // command codes
   // ************************************************************
   localparam logic [7:0] CMD_OPERATION = 8'h01;
   localparam logic [7:0] CMD_ON_OFF_CFG = 8'h02;
   localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
   localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int OP_EN_LSB = 6;
   localparam int OP_MRG_LSB = 4;
   localparam int OP_FLT_LSB = 2;
   localparam int CFG_PU_OP = 4;
   localparam int CFG_BUS_MODE = 3;
   localparam int CFG_PIN_MODE = 2;
   localparam int CFG_PIN_POL = 1;
   localparam int CFG_DIS_ACT = 0;
   localparam logic [7:0] OP_RESET = 8'h88;
   localparam logic [7:0] CFG_RESET = 8'h16;
   localparam logic [15:0] MARGIN_RESET = 16'h0000;

   // ************************************************************
   // field encodings
   // ************************************************************
   localparam logic [1:0] EN_IMM_OFF = 2'h0;
   localparam logic [1:0] EN_SOFT_OFF = 2'h1;
   localparam logic [1:0] EN_RUN = 2'h2;
   localparam logic [1:0] MRG_NOM = 2'h0;
   localparam logic [1:0] MRG_LOW = 2'h1;
   localparam logic [1:0] MRG_HIGH = 2'h2;
   localparam logic [1:0] FLT_IGNORE = 2'h1;
   localparam logic [1:0] FLT_ACT = 2'h2;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_KHZ = 20000;
   localparam int TOFF_DELAY_US = 5000;
   localparam int TOFF_FALL_US = 5000;
   localparam int TOFF_DELAY_CYCLES = TOFF_DELAY_US * CLK_KHZ / 1000;
   localparam int TOFF_FALL_CYCLES = TOFF_FALL_US * CLK_KHZ / 1000;
   localparam int CNT_W = 24;

   // ************************************************************
   // bus carriers and sequencer states
   // ************************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic word;
      logic [7:0] code;
      logic [15:0] data;
   } cmd_req_s;

   typedef struct packed {
      logic valid;
      logic ack;
      logic [15:0] data;
   } cmd_rsp_s;

   typedef enum logic [3:0] {
      ST_OFF = 4'b0001,
      ST_RUN = 4'b0010,
      ST_DELAY = 4'b0100,
      ST_FALL = 4'b1000
   } seq_e;

endpackage

// File: hw/en_margin_ctrl.sv
// enable, margin and turn-off sequencing control with its command registers
`timescale 1ns/1ps
module en_margin_ctrl
   import en_margin_pkg::*;
#(
   parameter int TOFF_DELAY_CYC = TOFF_DELAY_CYCLES,
   parameter int TOFF_FALL_CYC = TOFF_FALL_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire cmd_req_s cmd_req,
   output cmd_rsp_s cmd_rsp,
   input wire logic on_off_pin,
   input wire logic vin_present,
   input wire logic [15:0] nominal_target,
   output logic energy_en,
   output logic fall_active,
   output logic [15:0] target_value,
   output logic [1:0] margin_sel,
   output logic ov_uv_act,
   output logic output_on
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic pin_s1_r, pin_s2_r, vin_s1_r, vin_s2_r;

   // both levels come from outside the clock domain
   // the first stage may go metastable, so nothing but the second one reads it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         vin_s1_r <= 1'b0;
         vin_s2_r <= 1'b0;
      end else begin
         pin_s1_r <= on_off_pin;
         pin_s2_r <= pin_s1_r;
         vin_s1_r <= vin_present;
         vin_s2_r <= vin_s1_r;
      end
   end

   // ************************************************************
   // command registers
   // ************************************************************
   logic [7:0] op_r, op_nxt, cfg_r, cfg_nxt;
   logic [15:0] mhi_r, mhi_nxt, mlo_r, mlo_nxt;
   logic [1:0] en_eff_r, en_eff_nxt, mrg_eff_r, mrg_eff_nxt, flt_eff_r, flt_eff_nxt;
   cmd_rsp_s rsp_r, rsp_nxt;
   logic [1:0] f_en, f_mrg, f_flt;

   // field views of the incoming byte; the raw byte is kept as written for read-back,
   // while the effective copies hold only legal codes and drive the outputs
   assign f_en = cmd_req.data[OP_EN_LSB +: 2];
   assign f_mrg = cmd_req.data[OP_MRG_LSB +: 2];
   assign f_flt = cmd_req.data[OP_FLT_LSB +: 2];

   // decode one command per cycle; byte codes refuse word access and back
   always_comb begin
      op_nxt = op_r;
      cfg_nxt = cfg_r;
      mhi_nxt = mhi_r;
      mlo_nxt = mlo_r;
      en_eff_nxt = en_eff_r;
      mrg_eff_nxt = mrg_eff_r;
      flt_eff_nxt = flt_eff_r;
      rsp_nxt = '0;
      if (cmd_req.wr || cmd_req.rd) begin
         rsp_nxt.valid = 1'b1;
         unique case (cmd_req.code)
            CMD_OPERATION: begin
               rsp_nxt.ack = !cmd_req.word;
               rsp_nxt.data = {8'h00, op_r};
               if (cmd_req.wr && !cmd_req.word) begin
                  op_nxt = cmd_req.data[7:0];
                  // undefined field codes keep the last legal choice
                  if (f_en != 2'h3) begin
                     en_eff_nxt = f_en;
                  end
                  if (f_mrg != 2'h3) begin
                     mrg_eff_nxt = f_mrg;
                  end
                  if (f_flt == FLT_ACT || f_flt == FLT_IGNORE) begin
                     flt_eff_nxt = f_flt;
                  end
               end
            end
            CMD_ON_OFF_CFG: begin
               rsp_nxt.ack = !cmd_req.word;
               rsp_nxt.data = {8'h00, cfg_r};
               if (cmd_req.wr && !cmd_req.word) begin
                  cfg_nxt = cmd_req.data[7:0];
               end
            end
            CMD_MARGIN_HIGH: begin
               rsp_nxt.ack = cmd_req.word;
               rsp_nxt.data = mhi_r;
               if (cmd_req.wr && cmd_req.word) begin
                  mhi_nxt = cmd_req.data;
               end
            end
            CMD_MARGIN_LOW: begin
               rsp_nxt.ack = cmd_req.word;
               rsp_nxt.data = mlo_r;
               if (cmd_req.wr && cmd_req.word) begin
                  mlo_nxt = cmd_req.data;
               end
            end
            default: begin
               rsp_nxt.ack = 1'b0; // other codes belong to other blocks
            end
         endcase
         // a write answer carries no data, nor does a refused access
         if (!rsp_nxt.ack || cmd_req.wr) begin
            rsp_nxt.data = 16'h0000;
         end
      end
   end

   // registers only; every decision is made in the decode process above
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         op_r <= OP_RESET;
         cfg_r <= CFG_RESET;
         mhi_r <= MARGIN_RESET;
         mlo_r <= MARGIN_RESET;
         en_eff_r <= OP_RESET[OP_EN_LSB +: 2];
         mrg_eff_r <= OP_RESET[OP_MRG_LSB +: 2];
         flt_eff_r <= OP_RESET[OP_FLT_LSB +: 2];
         rsp_r <= '0;
      end else begin
         op_r <= op_nxt;
         cfg_r <= cfg_nxt;
         mhi_r <= mhi_nxt;
         mlo_r <= mlo_nxt;
         en_eff_r <= en_eff_nxt;
         mrg_eff_r <= mrg_eff_nxt;
         flt_eff_r <= flt_eff_nxt;
         rsp_r <= rsp_nxt;
      end
   end

   // registered answer: it stands for exactly one cycle after the request
   assign cmd_rsp = rsp_r;

   // ************************************************************
   // run decision
   // ************************************************************
   // the run decision works on synchronised levels only, so a pin that moves
   // near a clock edge costs at most one extra cycle of latency
   logic pin_asserted, pin_ok, bus_ok, run_req, pin_stop, bus_stop, imm_stop;

   // polarity chosen in software, applied after synchronising
   assign pin_asserted = cfg_r[CFG_PIN_POL] ? pin_s2_r : !pin_s2_r;
   assign pin_ok = !cfg_r[CFG_PIN_MODE] || pin_asserted;
   assign bus_ok = !cfg_r[CFG_BUS_MODE] || en_eff_r == EN_RUN;

   // always-on ignores pin and bus; otherwise both gates must agree
   always_comb begin
      if (!cfg_r[CFG_PU_OP]) begin
         run_req = vin_s2_r;
      end else begin
         run_req = vin_s2_r && pin_ok && bus_ok;
      end
   end

   // the source of a stop chooses soft or immediate; immediate wins a tie
   assign pin_stop = cfg_r[CFG_PU_OP] && !pin_ok;
   assign bus_stop = cfg_r[CFG_PU_OP] && !bus_ok;
   always_comb begin
      // loss of input power always stops at once: nothing is left to ramp with
      imm_stop = !vin_s2_r;
      if (pin_stop && cfg_r[CFG_DIS_ACT]) begin
         imm_stop = 1'b1;
      end
      if (bus_stop && en_eff_r == EN_IMM_OFF) begin
         imm_stop = 1'b1;
      end
   end

   // ************************************************************
   // turn-off sequencer
   // ************************************************************
   // counters load the count minus one so each stage lasts exactly its count;
   // CNT_W must cover the longest count, 5 ms at 20 MHz fits in 24 bits
   seq_e st_r, st_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;

   // soft stop walks through delay then fall; a renewed run aborts the delay
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      unique case (st_r)
         ST_OFF: begin
            // start as soon as every enabling condition holds
            if (run_req) begin
               st_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            // the cause of the stop picks its kind
            if (!run_req) begin
               if (imm_stop) begin
                  st_nxt = ST_OFF;
               end else begin
                  st_nxt = ST_DELAY;
                  cnt_nxt = CNT_W'(TOFF_DELAY_CYC - 1);
               end
            end
         end
         ST_DELAY: begin
            if (run_req) begin
               st_nxt = ST_RUN;
            end else if (imm_stop) begin
               st_nxt = ST_OFF;
            end else if (cnt_r == '0) begin
               st_nxt = ST_FALL;
               cnt_nxt = CNT_W'(TOFF_FALL_CYC - 1);
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
         ST_FALL: begin
            // a fall under way completes before a restart
            if (imm_stop || cnt_r == '0) begin
               st_nxt = ST_OFF;
            end else begin
               cnt_nxt = cnt_r - CNT_W'(1);
            end
         end
      endcase
   end

   // state and counter register; reset parks the stage off
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_OFF;
         cnt_r <= '0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   logic energy_r, energy_nxt, fall_r, fall_nxt, on_r, on_nxt, act_r, act_nxt;
   logic [15:0] tgt_r, tgt_nxt;

   // target and fault gating come from the next margin choice, so they settle
   // in the same cycle as margin_sel and never lag it by one
   always_comb begin
      unique case (mrg_eff_nxt)
         MRG_LOW: tgt_nxt = mlo_nxt;
         MRG_HIGH: tgt_nxt = mhi_nxt;
         default: tgt_nxt = nominal_target;
      endcase
      // nominal always acts; margined follows the fault field
      act_nxt = mrg_eff_nxt == MRG_NOM || flt_eff_nxt == FLT_ACT;
   end

   // status levels decoded from the next state, so they switch with st_r
   always_comb begin
      energy_nxt = st_nxt != ST_OFF;
      fall_nxt = st_nxt == ST_FALL;
      on_nxt = st_nxt == ST_RUN;
   end

   // output registers; reset shows a dead stage that still acts on faults
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         energy_r <= 1'b0;
         fall_r <= 1'b0;
         on_r <= 1'b0;
         act_r <= 1'b1;
         tgt_r <= 16'h0000;
      end else begin
         energy_r <= energy_nxt;
         fall_r <= fall_nxt;
         on_r <= on_nxt;
         act_r <= act_nxt;
         tgt_r <= tgt_nxt;
      end
   end

   assign energy_en = energy_r;
   assign fall_active = fall_r;
   assign output_on = on_r;
   assign ov_uv_act = act_r;
   assign target_value = tgt_r;
   // the effective register itself, already free of the undefined code
   assign margin_sel = mrg_eff_r;

endmodule

// File: bench/en_margin_monitor.sv
// port assertions for the enable and margin control block
`timescale 1ns/1ps
module en_margin_monitor
   import en_margin_pkg::*;
#(
   parameter int TOFF_DELAY_CYC = 8,
   parameter int TOFF_FALL_CYC = 6
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire cmd_req_s cmd_req,
   input wire cmd_rsp_s cmd_rsp,
   input wire logic on_off_pin,
   input wire logic vin_present,
   input wire logic [15:0] nominal_target,
   input wire logic energy_en,
   input wire logic fall_active,
   input wire logic [15:0] target_value,
   input wire logic [1:0] margin_sel,
   input wire logic ov_uv_act,
   input wire logic output_on
);
   default clocking dc @(posedge clock); endclocking
   default disable iff (!rst_n);
   int fall_cnt_r;
   int fall_cnt_nxt;
   // ramp length counter, too long for a repetition
   always_comb fall_cnt_nxt = fall_active ? fall_cnt_r + 1 : 0;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fall_cnt_r <= 0;
      end else begin
         fall_cnt_r <= fall_cnt_nxt;
      end
   end
   sequence s_req;
      cmd_req.wr || cmd_req.rd;
   endsequence
   sequence s_soft_stop;
      $fell(output_on) && energy_en;
   endsequence
   a_rsp_next_cycle: assert property (s_req |=> cmd_rsp.valid)
      else $error("no answer after request");
   a_no_stray_rsp: assert property (cmd_rsp.valid |-> $past(cmd_req.wr) || $past(cmd_req.rd))
      else $error("answer without request");
   a_write_data_zero: assert property (cmd_req.wr |=> cmd_rsp.data == 16'h0000)
      else $error("write answer carries data");
   a_margin_defined: assert property (margin_sel != 2'h3)
      else $error("undefined margin code");
   a_nominal_acts: assert property (margin_sel == MRG_NOM |-> ov_uv_act)
      else $error("faults ignored at nominal");
   a_on_energy: assert property (output_on |-> energy_en)
      else $error("running without energy");
   a_fall_state: assert property (fall_active |-> energy_en && !output_on)
      else $error("fall outside soft stop");
   a_delay_first: assert property (s_soft_stop |-> !fall_active ##1 !fall_active)
      else $error("fall before turn-off delay");
   a_fall_bound: assert property (fall_cnt_r <= TOFF_FALL_CYC)
      else $error("fall ramp too long");
   a_vin_loss: assert property ($fell(vin_present) |-> ##[1:4] !energy_en)
      else $error("energy kept after power loss");
endmodule
bind en_margin_ctrl en_margin_monitor #(.TOFF_DELAY_CYC(TOFF_DELAY_CYC),
   .TOFF_FALL_CYC(TOFF_FALL_CYC)) mon_i (.clock(clock), .rst_n(rst_n), .cmd_req(cmd_req),
   .cmd_rsp(cmd_rsp), .on_off_pin(on_off_pin), .vin_present(vin_present),
   .nominal_target(nominal_target), .energy_en(energy_en), .fall_active(fall_active),
   .target_value(target_value), .margin_sel(margin_sel), .ov_uv_act(ov_uv_act),
   .output_on(output_on));

// File: bench/host_pin_model.sv
// host and on/off pin driver model facing the control block
`timescale 1ns/1ps
module host_pin_model
   import en_margin_pkg::*;
(
   input wire logic clock,
   input wire cmd_rsp_s cmd_rsp,
   output cmd_req_s cmd_req,
   output logic on_off_pin,
   output logic vin_present
);
   initial begin
      cmd_req = '0;
      on_off_pin = 1'h0;
      vin_present = 1'h0;
   end
   // one request held over its taking edge; answer awaited a bounded time
   task automatic xfer(input logic wr, input logic word, input logic [7:0] code,
      input logic [15:0] data, output logic ack, output logic [15:0] rdata, output logic ok);
      int i;
      @(negedge clock);
      cmd_req = '{wr, !wr, word, code, data};
      @(negedge clock);
      cmd_req = '0;
      ok = 1'h0;
      ack = 1'h0;
      rdata = 16'h0000;
      for (i = 0; i < 3 && !ok; i++) begin
         if (cmd_rsp.valid === 1'h1) begin
            ok = 1'h1;
            ack = cmd_rsp.ack;
            rdata = cmd_rsp.data;
         end else begin
            @(negedge clock);
         end
      end
   endtask
   // pin and power levels change off the sampling edge
   task automatic set_pin(input logic p, input logic v);
      @(negedge clock);
      on_off_pin = p;
      vin_present = v;
   endtask
endmodule

// File: bench/testbench.sv
// self-checking bench for the enable and margin control block
`timescale 1ns/1ps
module testbench
   import en_margin_pkg::*;
;
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   cmd_req_s cmd_req;
   cmd_rsp_s cmd_rsp;
   logic on_off_pin, vin_present, energy_en, fall_active, ov_uv_act, output_on;
   logic [15:0] target_value;
   logic [1:0] margin_sel;
   logic [15:0] nominal = 16'h0abc;
   logic [7:0] op;
   int miscompares, checks_done, dly, fall;
   logic [15:0] tgt [3] = '{16'h0abc, 16'h0567, 16'h1234};
   // rows: expected run, config, operation, pin
   logic [17:0] rt [10] = '{18'h22d11, 18'h02d10, 18'h22910, 18'h22810, 18'h03810,
      18'h03911, 18'h23910, 18'h03091, 18'h22010, 18'h20011};
   always #25 clock = ~clock;
   // short counts keep the turn-off sequence quick
   en_margin_ctrl #(.TOFF_DELAY_CYC(8), .TOFF_FALL_CYC(6)) en_margin_ctrl_i (.clock(clock),
      .rst_n(rst_n), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp), .on_off_pin(on_off_pin),
      .vin_present(vin_present), .nominal_target(nominal), .energy_en(energy_en),
      .fall_active(fall_active), .target_value(target_value), .margin_sel(margin_sel),
      .ov_uv_act(ov_uv_act), .output_on(output_on));
   host_pin_model host_pin_model_i (.clock(clock), .cmd_rsp(cmd_rsp), .cmd_req(cmd_req),
      .on_off_pin(on_off_pin), .vin_present(vin_present));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // one command access with its expected acknowledge and data
   task automatic acc(input logic wr, input logic word, input logic [7:0] code,
      input logic [15:0] d, input logic ea, input logic [15:0] ed);
      logic a;
      logic [15:0] r;
      logic ok;
      host_pin_model_i.xfer(wr, word, code, d, a, r, ok);
      if (!ok) begin
         miscompares++;
         end_sim();
      end
      chk({15'h0, a}, {15'h0, ea});
      chk(r, ed);
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clock);
   endtask
   // hang guard
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (16) @(negedge clock);
      rst_n = 1'h1;
      acc(1'h0, 1'h0, CMD_OPERATION, 16'h0000, 1'h1, 16'h0088);
      acc(1'h0, 1'h0, CMD_ON_OFF_CFG, 16'h0000, 1'h1, 16'h0016);
      acc(1'h1, 1'h1, CMD_MARGIN_HIGH, 16'h1234, 1'h1, 16'h0000);
      acc(1'h1, 1'h1, CMD_MARGIN_LOW, 16'h0567, 1'h1, 16'h0000);
      acc(1'h0, 1'h1, CMD_MARGIN_HIGH, 16'h0000, 1'h1, 16'h1234);
      acc(1'h0, 1'h0, CMD_MARGIN_LOW, 16'h0000, 1'h0, 16'h0000);
      acc(1'h1, 1'h1, CMD_OPERATION, 16'h0048, 1'h0, 16'h0000);
      acc(1'h1, 1'h0, 8'h03, 16'h0000, 1'h0, 16'h0000);
      acc(1'h0, 1'h0, CMD_OPERATION, 16'h0000, 1'h1, 16'h0088);
      host_pin_model_i.set_pin(1'h1, 1'h1);
      // each margin code, faults ignored while margined
      for (int m = 0; m < 3; m++) begin
         op = {EN_RUN, m[1:0], FLT_IGNORE, 2'h0};
         acc(1'h1, 1'h0, CMD_OPERATION, {8'h00, op}, 1'h1, 16'h0000);
         wt(4);
         chk({14'h0, margin_sel}, {14'h0, m[1:0]});
         chk(target_value, tgt[m]);
         chk({15'h0, ov_uv_act}, {15'h0, m == 0});
      end
      acc(1'h1, 1'h0, CMD_OPERATION, 16'h00a8, 1'h1, 16'h0000);
      wt(4);
      chk({15'h0, ov_uv_act}, 16'h0001);
      // undefined margin code keeps the old selection, byte still reads back
      acc(1'h1, 1'h0, CMD_OPERATION, 16'h00b8, 1'h1, 16'h0000);
      wt(4);
      chk({14'h0, margin_sel}, {14'h0, MRG_HIGH});
      acc(1'h0, 1'h0, CMD_OPERATION, 16'h0000, 1'h1, 16'h00b8);
      // run decision over config, command and pin combinations
      for (int i = 0; i < 10; i++) begin
         acc(1'h1, 1'h0, CMD_ON_OFF_CFG, {8'h00, rt[i][16:9]}, 1'h1, 16'h0000);
         acc(1'h1, 1'h0, CMD_OPERATION, {8'h00, rt[i][8:1]}, 1'h1, 16'h0000);
         host_pin_model_i.set_pin(rt[i][0], 1'h1);
         wt(30);
         chk({15'h0, output_on}, {15'h0, rt[i][17]});
      end
      // nominal target is tracked while not margined
      nominal = 16'h0def;
      wt(2);
      chk(target_value, 16'h0def);
      // bus-commanded stops: code 01 softly, code 00 at once
      acc(1'h1, 1'h0, CMD_ON_OFF_CFG, 16'h0018, 1'h1, 16'h0000);
      acc(1'h1, 1'h0, CMD_OPERATION, 16'h0088, 1'h1, 16'h0000);
      wt(10);
      acc(1'h1, 1'h0, CMD_OPERATION, 16'h0048, 1'h1, 16'h0000);
      wt(2);
      chk({14'h0, energy_en, output_on}, 16'h0002);
      wt(30);
      acc(1'h1, 1'h0, CMD_OPERATION, 16'h0088, 1'h1, 16'h0000);
      wt(10);
      chk({15'h0, output_on}, 16'h0001);
      acc(1'h1, 1'h0, CMD_OPERATION, 16'h0008, 1'h1, 16'h0000);
      wt(2);
      chk({14'h0, energy_en, output_on}, 16'h0000);
      // soft pin stop: delay then fall ramp
      acc(1'h1, 1'h0, CMD_ON_OFF_CFG, 16'h0016, 1'h1, 16'h0000);
      host_pin_model_i.set_pin(1'h1, 1'h1);
      wt(10);
      host_pin_model_i.set_pin(1'h0, 1'h1);
      dly = 0;
      fall = 0;
      for (int i = 0; i < 40; i++) begin
         @(negedge clock);
         if (energy_en === 1'h1 && output_on === 1'h0) begin
            if (fall_active === 1'h1) begin
               fall++;
            end else begin
               dly++;
            end
         end
      end
      chk(dly[15:0], 16'h0008);
      chk(fall[15:0], 16'h0006);
      // immediate pin stop, then loss of input power
      acc(1'h1, 1'h0, CMD_ON_OFF_CFG, 16'h0017, 1'h1, 16'h0000);
      host_pin_model_i.set_pin(1'h1, 1'h1);
      wt(10);
      host_pin_model_i.set_pin(1'h0, 1'h1);
      wt(4);
      chk({14'h0, energy_en, fall_active}, 16'h0000);
      host_pin_model_i.set_pin(1'h1, 1'h1);
      wt(10);
      host_pin_model_i.set_pin(1'h1, 1'h0);
      wt(4);
      chk({15'h0, energy_en}, 16'h0000);
      end_sim();
   end
endmodule
